// ### bench/pin_model.sv
// Purpose: Far-side pin model for the triple timer
// Assumes: Pins idle high; levels change at falling mclk
// Notes: Each pulse is low 4 cycles; pulses in one burst are high 5 cycles apart
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic mclk, // Core clock
  output logic t0_pin, // Timer 0 count
  output logic t1_pin, // Timer 1 count
  output logic irq0_pin, // Timer 0 gate
  output logic irq1_pin, // Timer 1 gate
  output logic trig_pin, // Timer 2 trigger
  output logic t2_pin // Timer 2 count
);
  logic [5:0] lv = 6'h3f;
  assign {t2_pin, trig_pin, irq1_pin, irq0_pin, t1_pin, t0_pin} = lv;
  // Slow pulses so the two-stage sync never misses an edge
  task automatic fall(input int k, input int n);
    repeat (n) begin
      @(negedge mclk);
      lv[k] = 1'b0;
      repeat (4) @(negedge mclk);
      lv[k] = 1'b1;
      repeat (4) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ### bench/tb_triple_timer_clock_out.sv
// Purpose: Self-checking bench for the triple timer
// Assumes: Overflow, capture, trigger and pin toggles are the events watched
// Notes: Notes queue holds source, interval and value
`timescale 1ns/1ps
`default_nettype none
module tb_triple_timer_clock_out;
  typedef struct packed {logic [2:0] src; logic [15:0] dt; logic [15:0] v;} note_s;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clk6_mode = 1'b0;
  logic [7:0] timer01_mode_reg = 8'h00, timer01_control_reg = 8'h00;
  logic [7:0] timer2_control_reg = 8'h00, timer2_mode_reg = 8'h00, byte_wdata = 8'h00;
  logic [7:0] timer2_reload_high = 8'h12, timer2_reload_low = 8'h34;
  logic [2:0] byte_we_low = 3'h0, byte_we_high = 3'h0, ovf_pulse;
  wire logic t0_count_pin, t1_count_pin, ext_irq0_pin, ext_irq1_pin, timer2_ext_trigger_pin, t2_far;
  logic timer2_clock_pin_out, timer2_clock_pin_oe, capture_valid, t0_high_ovf_pulse, t2_ext_pulse, baud_tick;
  logic [7:0] timer0_low_byte, timer0_high_byte, timer1_low_byte, timer1_high_byte;
  logic [7:0] timer2_low_byte, timer2_high_byte, capture_high, capture_low;
  // Pin is shared: the block wins while it drives
  wire logic timer2_clock_pin_in = timer2_clock_pin_oe ? timer2_clock_pin_out : t2_far;
  note_s q[$];
  int num_errors = 0, checked = 0, cyc = 0;
  int last [8];
  logic [7:0] watch = 8'h00, probe = 8'h00;
  logic [15:0] lfsr = 16'ha04c;
  logic prev_pin = 1'b0;

  triple_timer_clock_out DUT (.mclk, .arst_n, .clk6_mode, .timer01_mode_reg, .timer01_control_reg,
    .timer2_control_reg, .timer2_mode_reg, .timer2_reload_high, .timer2_reload_low, .byte_we_low,
    .byte_we_high, .byte_wdata, .t0_count_pin, .t1_count_pin, .ext_irq0_pin, .ext_irq1_pin,
    .timer2_ext_trigger_pin, .timer2_clock_pin_in, .timer2_clock_pin_out, .timer2_clock_pin_oe,
    .timer0_low_byte, .timer0_high_byte, .timer1_low_byte, .timer1_high_byte, .timer2_low_byte,
    .timer2_high_byte, .capture_high, .capture_low, .capture_valid, .ovf_pulse, .t0_high_ovf_pulse,
    .t2_ext_pulse, .baud_tick);
  pin_model pins (.mclk, .t0_pin(t0_count_pin), .t1_pin(t1_count_pin), .irq0_pin(ext_irq0_pin),
    .irq1_pin(ext_irq1_pin), .trig_pin(timer2_ext_trigger_pin), .t2_pin(t2_far));

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic end_sim();
    num_errors += q.size();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH src_dt_value exp %h seen %h", exp, seen);
    end
  endtask

  function automatic logic [2:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[2:0];
  endfunction

  function automatic logic [15:0] obs(input int s);
    case (s)
      0, 7: return {timer0_high_byte, timer0_low_byte};
      1, 6: return {timer1_high_byte, timer1_low_byte};
      2: return {timer2_high_byte, timer2_low_byte};
      3: return {capture_high, capture_low};
      4: return {15'h0, timer2_clock_pin_oe};
      default: return 16'h0;
    endcase
  endfunction

  always @(negedge mclk) begin : watcher
    logic [7:0] ev;
    note_s n;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
    ev = (watch & {t0_high_ovf_pulse, baud_tick, t2_ext_pulse, timer2_clock_pin_out != prev_pin, capture_valid,
      ovf_pulse}) | probe;
    prev_pin = timer2_clock_pin_out;
    for (int s = 0; s < 8; s++) begin
      if (ev[s] && q.size() == 0) begin
        chk({3'(s), 32'h0}, '1);
      end else if (ev[s]) begin
        n = q.pop_front();
        chk({3'(s), n.dt == 0 ? 16'h0 : 16'(cyc - last[s]), obs(s)}, n);
      end
      if (ev[s]) last[s] = cyc;
    end
  end

  task automatic note(input int s, input int dt, input logic [15:0] v);
    q.push_back({3'(s), 16'(dt), v});
  endtask

  task automatic look(input int s, input logic [15:0] v);
    note(s, 0, v);
    @(posedge mclk) probe[s] <= 1'b1;
    @(posedge mclk) probe[s] <= 1'b0;
  endtask

  task automatic drain(input int lim);
    repeat (lim) if (q.size() != 0) @(negedge mclk);
  endtask

  task automatic wr(input int i, input logic [15:0] v);
    @(negedge mclk);
    byte_we_low[i] = 1'b1;
    byte_wdata = v[7:0];
    @(negedge mclk);
    byte_we_low[i] = 1'b0;
    byte_we_high[i] = 1'b1;
    byte_wdata = v[15:8];
    @(negedge mclk);
    byte_we_high[i] = 1'b0;
  endtask

  // 8-bit reload mode, software or pin-gated run
  task automatic t8(input int i, input logic ext);
    logic [7:0] rl;
    rl = {5'h1e, rnd()};
    timer01_mode_reg = 8'({ext, 3'b010}) << (4 * i);
    wr(i, {rl, rl});
    watch = 8'h01 << i;
    timer01_control_reg = 8'h10 << (2 * i);
    note(i, 0, {rl, rl});
    note(i, (256 - rl) * (clk6_mode ? 6 : 12), {rl, rl});
    if (ext) begin
      repeat (300) @(negedge mclk);
      pins.fall(2 + i, 1);
    end
    drain(3000);
    if (ext) begin
      pins.fall(2 + i, 1);
      repeat (400) @(negedge mclk);
    end
    timer01_control_reg = 8'h00;
    watch = 8'h00;
  endtask

  task automatic clk_out(input logic c6);
    clk6_mode = c6;
    timer2_reload_high = 8'hff;
    timer2_reload_low = 8'hf0;
    wr(2, 16'hfff0);
    timer2_mode_reg = 8'h02;
    timer2_control_reg = 8'h04;
    watch = 8'h14;
    note(4, 0, 16'h1);
    repeat (2) note(4, c6 ? 16 : 32, 16'h1);
    drain(300);
    timer2_control_reg = 8'h00;
    timer2_mode_reg = 8'h00;
    watch = 8'h00;
  endtask

  // Count five pin edges, then one trigger edge
  task automatic trig(input logic [7:0] ctl, input logic [7:0] w, input int s, input logic [15:0] v);
    timer2_reload_high = 8'h12;
    timer2_reload_low = 8'h34;
    wr(2, 16'h0000);
    timer2_control_reg = ctl;
    pins.fall(5, 5);
    watch = w;
    if (s == 3) note(3, 0, v);
    pins.fall(4, 1);
    repeat (40) @(negedge mclk);
    if (s == 2) look(2, v);
    watch = 8'h00;
    timer2_control_reg = 8'h00;
  endtask

  initial begin
    logic [15:0] hv;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (5) @(negedge mclk);
    for (int c = 0; c < 2; c++) begin
      clk6_mode = c[0];
      for (int i = 0; i < 4; i++) t8(i / 2, i[0]);
    end
    void'(rnd());
    hv = lfsr;
    timer01_mode_reg = 8'h30;
    timer01_control_reg = 8'h40;
    watch = 8'h02;
    wr(1, hv);
    repeat (300) @(negedge mclk);
    look(6, hv);
    watch = 8'h00;
    // Baud and clock out together; timer 1 still holds hv
    timer2_reload_high = 8'hff;
    timer2_reload_low = 8'hf8;
    wr(2, 16'hfff8);
    timer2_mode_reg = 8'h02;
    watch = 8'h54;
    timer2_control_reg = 8'h34;
    for (int k = 0; k < 2; k++) begin
      note(4, 8 * k, 16'h1);
      note(6, 8 * k, hv);
    end
    drain(200);
    timer2_control_reg = 8'h00;
    timer2_mode_reg = 8'h00;
    watch = 8'h00;
    for (int i = 0; i < 2; i++) begin
      timer01_control_reg = 8'h00;
      timer01_mode_reg = 8'h05 << (4 * i);
      wr(i, 16'hfffd);
      watch = 8'h01 << i;
      timer01_control_reg = 8'h10 << (2 * i);
      note(i, 0, 16'h0000);
      pins.fall(i, 3);
      drain(50);
      timer01_control_reg = 8'h00;
      watch = 8'h00;
    end
    timer01_mode_reg = 8'h03;
    wr(0, 16'hfe00);
    watch = 8'h80;
    timer01_control_reg = 8'h40;
    note(7, 0, 16'h0000);
    drain(100);
    timer01_control_reg = 8'h00;
    watch = 8'h00;
    clk_out(1'b0);
    clk_out(1'b1);
    timer2_reload_low = 8'hf8;
    wr(2, 16'hfffe);
    watch = 8'h04;
    timer2_control_reg = 8'h04;
    note(2, 0, 16'hfff8);
    note(2, 8 * 6, 16'hfff8);
    drain(300);
    timer2_control_reg = 8'h00;
    watch = 8'h00;
    trig(8'h0f, 8'h08, 3, 16'h0005);
    trig(8'h07, 8'h08, -1, 16'h0000);
    trig(8'h0e, 8'h08, 2, 16'h1234);
    trig(8'h36, 8'h28, -1, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire

// ### core/timer_map.svh
// Purpose: Constants for the triple timer block
// Assumes: 8-bit control registers, standard bit positions
// Notes: Included by the core only
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define T01_MODE_RESET 8'h00
`define T01_CTRL_RESET 8'h00
`define T2_CTRL_RESET 8'h00
`define T2_MODE_RESET 8'h00
`define T2_EXT_ENABLE_BIT 3
`define T2_RUN_BIT 2
`define T2_COUNTER_BIT 1
`define T2_CAPTURE_BIT 0
`define T2_RCLK_BIT 5
`define T2_TCLK_BIT 4
`define T2_OUT_ENABLE_BIT 1
`define T0_RUN_BIT 4
`define T1_RUN_BIT 6
`define T0_OVF_BIT 5
`define T1_OVF_BIT 7
`define T2_OVF_BIT 7
`define T2_EXF_BIT 6
`define CYCLES_6CLK 4'd5
`define CYCLES_12CLK 4'd11
`endif

// ### core/timer_pkg.sv
// Purpose: Types for the triple timer block
// Assumes: Constants come from the map header
// Notes: Mode field of a 4-bit timer slice
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8RELOAD,
    MODE_SPLIT
  } tmode_e;
endpackage

// ### core/triple_timer_clock_out.sv
// Purpose: Three 16-bit timer/counters with programmable clock out
// Assumes: Control registers written by the core as plain ports
// Notes: Overflow flags are pulses; the core owns the sticky flags
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"
module triple_timer_clock_out
  import timer_pkg::*;
(
  input wire logic mclk, // 20 MHz core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic clk6_mode, // High selects 6-clock machine cycle
  input wire logic [7:0] timer01_mode_reg, // Timer 0/1 mode
  input wire logic [7:0] timer01_control_reg, // Run bits
  input wire logic [7:0] timer2_control_reg, // Timer 2 control
  input wire logic [7:0] timer2_mode_reg, // Timer 2 mode
  input wire logic [7:0] timer2_reload_high, // Reload value high; capture goes to capture_high
  input wire logic [7:0] timer2_reload_low, // Reload value low; capture goes to capture_low
  input wire logic [2:0] byte_we_low, // Write strobe per timer low byte
  input wire logic [2:0] byte_we_high, // Write strobe per timer high byte
  input wire logic [7:0] byte_wdata, // Byte write data
  input wire logic t0_count_pin, // Timer 0 count input
  input wire logic t1_count_pin, // Timer 1 count input
  input wire logic ext_irq0_pin, // Timer 0 gate pin
  input wire logic ext_irq1_pin, // Timer 1 gate pin
  input wire logic timer2_ext_trigger_pin, // Timer 2 trigger
  input wire logic timer2_clock_pin_in, // Timer 2 pin level
  output logic timer2_clock_pin_out, // Clock-out level
  output logic timer2_clock_pin_oe, // Drive enable for clock out
  output logic [7:0] timer0_low_byte, // Timer 0 low
  output logic [7:0] timer0_high_byte, // Timer 0 high
  output logic [7:0] timer1_low_byte, // Timer 1 low
  output logic [7:0] timer1_high_byte, // Timer 1 high
  output logic [7:0] timer2_low_byte, // Timer 2 low
  output logic [7:0] timer2_high_byte, // Timer 2 high
  output logic [7:0] capture_high, // Captured high byte
  output logic [7:0] capture_low, // Captured low byte
  output logic capture_valid, // One-cycle pulse: capture taken
  output logic [2:0] ovf_pulse, // Overflow pulse per timer (t0,t1,t2)
  output logic t0_high_ovf_pulse, // Split-mode high byte overflow
  output logic t2_ext_pulse, // Trigger edge acted on
  output logic baud_tick // Timer 2 baud overflow pulse
);
  logic rst_s1, rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Pin synchronisers, then one edge register each
  logic [4:0] pin_raw, pin_s1, pin_s2, pin_d;
  assign pin_raw = {timer2_clock_pin_in, timer2_ext_trigger_pin, ext_irq1_pin, ext_irq0_pin, t0_count_pin};
  logic t1c_s1, t1c_s2, t1c_d;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
      pin_d <= 5'h1f;
      t1c_s1 <= 1'b1;
      t1c_s2 <= 1'b1;
      t1c_d <= 1'b1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      t1c_s1 <= t1_count_pin;
      t1c_s2 <= t1c_s1;
      t1c_d <= t1c_s2;
    end
  end
  logic [4:0] fall;
  assign fall = pin_d & ~pin_s2;
  logic t1_fall;
  assign t1_fall = t1c_d & ~t1c_s2;

  // Machine-cycle enable from the core clock
  logic [3:0] cyc_cnt;
  logic mc_tick;
  logic [3:0] cyc_max;
  assign cyc_max = clk6_mode ? `CYCLES_6CLK : `CYCLES_12CLK;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cyc_cnt <= 4'h0;
    else if (cyc_cnt >= cyc_max) cyc_cnt <= 4'h0;
    else cyc_cnt <= cyc_cnt + 4'h1;
  end
  assign mc_tick = (cyc_cnt == cyc_max);

  // Gate toggles: each falling edge on the gate pin flips on/off while the run bit is set
  logic [1:0] gate_on;
  logic [1:0] run_bit, ext_ctl;
  assign run_bit = {timer01_control_reg[`T1_RUN_BIT], timer01_control_reg[`T0_RUN_BIT]};
  assign ext_ctl = {timer01_mode_reg[7], timer01_mode_reg[3]};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) gate_on <= 2'b00;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (!run_bit[i]) gate_on[i] <= 1'b0;
        else if (fall[i + 1]) gate_on[i] <= ~gate_on[i];
      end
    end
  end

  logic [1:0] run01, inc01;
  logic [1:0] ctr_sel;
  assign ctr_sel = {timer01_mode_reg[6], timer01_mode_reg[2]};
  assign run01 = run_bit & (~ext_ctl | gate_on);
  assign inc01[0] = run01[0] & (ctr_sel[0] ? fall[0] : mc_tick);
  assign inc01[1] = run01[1] & (ctr_sel[1] ? t1_fall : mc_tick);

  tmode_e m0, m1;
  assign m0 = tmode_e'(timer01_mode_reg[1:0]);
  assign m1 = tmode_e'(timer01_mode_reg[5:4]);

  // Timer 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer0_low_byte <= 8'h00;
      timer0_high_byte <= 8'h00;
      ovf_pulse[0] <= 1'b0;
      t0_high_ovf_pulse <= 1'b0;
    end else begin
      ovf_pulse[0] <= 1'b0;
      t0_high_ovf_pulse <= 1'b0;
      if (inc01[0]) begin
        case (m0)
          MODE_13BIT: begin
            timer0_low_byte <= {3'h0, timer0_low_byte[4:0] + 5'h01};
            if (timer0_low_byte[4:0] == 5'h1f) begin
              timer0_high_byte <= timer0_high_byte + 8'h01;
              ovf_pulse[0] <= (timer0_high_byte == 8'hff);
            end
          end
          MODE_16BIT: begin
            timer0_low_byte <= timer0_low_byte + 8'h01;
            if (timer0_low_byte == 8'hff) begin
              timer0_high_byte <= timer0_high_byte + 8'h01;
              ovf_pulse[0] <= (timer0_high_byte == 8'hff);
            end
          end
          MODE_8RELOAD: begin
            timer0_low_byte <= (timer0_low_byte == 8'hff) ? timer0_high_byte : timer0_low_byte + 8'h01;
            ovf_pulse[0] <= (timer0_low_byte == 8'hff);
          end
          default: begin
            timer0_low_byte <= timer0_low_byte + 8'h01;
            ovf_pulse[0] <= (timer0_low_byte == 8'hff);
          end
        endcase
      end
      // Split mode: high byte is a timer run by timer 1's run bit
      if (m0 == MODE_SPLIT && run_bit[1] && mc_tick) begin
        timer0_high_byte <= timer0_high_byte + 8'h01;
        t0_high_ovf_pulse <= (timer0_high_byte == 8'hff);
      end
      if (byte_we_low[0]) timer0_low_byte <= byte_wdata;
      if (byte_we_high[0]) timer0_high_byte <= byte_wdata;
    end
  end

  // Timer 1; mode 3 holds the count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_low_byte <= 8'h00;
      timer1_high_byte <= 8'h00;
      ovf_pulse[1] <= 1'b0;
    end else begin
      ovf_pulse[1] <= 1'b0;
      if (inc01[1]) begin
        case (m1)
          MODE_13BIT: begin
            timer1_low_byte <= {3'h0, timer1_low_byte[4:0] + 5'h01};
            if (timer1_low_byte[4:0] == 5'h1f) begin
              timer1_high_byte <= timer1_high_byte + 8'h01;
              ovf_pulse[1] <= (timer1_high_byte == 8'hff);
            end
          end
          MODE_16BIT: begin
            timer1_low_byte <= timer1_low_byte + 8'h01;
            if (timer1_low_byte == 8'hff) begin
              timer1_high_byte <= timer1_high_byte + 8'h01;
              ovf_pulse[1] <= (timer1_high_byte == 8'hff);
            end
          end
          MODE_8RELOAD: begin
            timer1_low_byte <= (timer1_low_byte == 8'hff) ? timer1_high_byte : timer1_low_byte + 8'h01;
            ovf_pulse[1] <= (timer1_low_byte == 8'hff);
          end
          default: ;
        endcase
      end
      if (byte_we_low[1]) timer1_low_byte <= byte_wdata;
      if (byte_we_high[1]) timer1_high_byte <= byte_wdata;
    end
  end

  // Timer 2
  logic t2_run, t2_ctr, t2_cap, t2_exen, t2_baud, t2_oe, t2_inc, t2_wrap, t2_trig;
  logic [15:0] t2_cnt, t2_reload;
  assign t2_run = timer2_control_reg[`T2_RUN_BIT];
  assign t2_ctr = timer2_control_reg[`T2_COUNTER_BIT];
  assign t2_cap = timer2_control_reg[`T2_CAPTURE_BIT];
  assign t2_exen = timer2_control_reg[`T2_EXT_ENABLE_BIT];
  assign t2_baud = timer2_control_reg[`T2_RCLK_BIT] | timer2_control_reg[`T2_TCLK_BIT];
  assign t2_oe = timer2_mode_reg[`T2_OUT_ENABLE_BIT] & ~t2_ctr;
  assign t2_cnt = {timer2_high_byte, timer2_low_byte};
  assign t2_reload = {timer2_reload_high, timer2_reload_low};
  // Baud and clock-out count at half the core clock (full clock in 6-clock mode), giving n = 2 then 4 with the toggle in 12-clock mode
  logic half_tick;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) half_tick <= 1'b0;
    else half_tick <= ~half_tick;
  end
  logic fast_mode;
  assign fast_mode = t2_baud | t2_oe;
  logic fast_en;
  assign fast_en = clk6_mode ? 1'b1 : half_tick;
  assign t2_inc = t2_run & (t2_ctr ? fall[4] : (fast_mode ? fast_en : mc_tick));
  assign t2_wrap = t2_inc & (t2_cnt == 16'hffff);
  assign t2_trig = t2_exen & fall[3] & ~t2_baud;
  logic [15:0] next_t2;
  always_comb begin
    next_t2 = t2_cnt;
    if (t2_wrap) next_t2 = (t2_cap && !fast_mode) ? 16'h0000 : t2_reload;
    else if (t2_inc) next_t2 = t2_cnt + 16'h0001;
    if (t2_trig && !t2_cap) next_t2 = t2_reload;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer2_low_byte <= 8'h00;
      timer2_high_byte <= 8'h00;
      capture_high <= 8'h00;
      capture_low <= 8'h00;
      capture_valid <= 1'b0;
      ovf_pulse[2] <= 1'b0;
      baud_tick <= 1'b0;
      t2_ext_pulse <= 1'b0;
      timer2_clock_pin_out <= 1'b0;
      timer2_clock_pin_oe <= 1'b0;
    end else begin
      timer2_low_byte <= byte_we_low[2] ? byte_wdata : next_t2[7:0];
      timer2_high_byte <= byte_we_high[2] ? byte_wdata : next_t2[15:8];
      capture_valid <= t2_trig & t2_cap;
      if (t2_trig && t2_cap) begin
        capture_high <= timer2_high_byte;
        capture_low <= timer2_low_byte;
      end
      ovf_pulse[2] <= t2_wrap & ~fast_mode;
      baud_tick <= t2_wrap & t2_baud;
      t2_ext_pulse <= t2_trig;
      timer2_clock_pin_oe <= t2_oe;
      if (!t2_oe) timer2_clock_pin_out <= 1'b0;
      else if (t2_wrap) timer2_clock_pin_out <= ~timer2_clock_pin_out;
    end
  end

  chk_baud_no_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    (t2_wrap && fast_mode) |=> !ovf_pulse[2]) else $error("timer 2 irq in baud/clock-out");
  chk_trig_baud: assert property (@(posedge mclk) disable iff (!rst_n)
    (t2_baud && fall[3]) |=> (!t2_ext_pulse && !capture_valid)) else $error("trigger acted in baud mode");
  chk_t1_mode3: assert property (@(posedge mclk) disable iff (!rst_n)
    (m1 == MODE_SPLIT && !byte_we_low[1]) |=> $stable(timer1_low_byte)) else $error("timer 1 ran in mode 3");
  chk_t0_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    (!run_bit[0] && !byte_we_low[0]) |=> $stable(timer0_low_byte)) else $error("timer 0 ran while stopped");
  chk_t1_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    (!run_bit[1] && !byte_we_low[1]) |=> $stable(timer1_low_byte)) else $error("timer 1 ran while stopped");
  chk_gate_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_bit[0] && $past(run_bit[0]) && $past(fall[1])) |-> (gate_on[0] != $past(gate_on[0]))) else $error("gate 0 no toggle");
  chk_clock_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (t2_wrap && t2_oe && $past(t2_oe)) |=> (timer2_clock_pin_out != $past(timer2_clock_pin_out))) else $error("clock out missed toggle");
  chk_reload_ovf: assert property (@(posedge mclk) disable iff (!rst_n)
    (t2_wrap && !t2_cap && !byte_we_low[2] && !byte_we_high[2]) |=> (t2_cnt == $past(t2_reload))) else $error("no reload");
endmodule
`default_nettype wire
